// [common/tmr_pkg.sv]
/*
 Package for the dual timer/counter block: register addresses, bit positions,
 reset values and mode codes. Assumes an 8-bit special-function-register port.
*/
package tmr_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_CNT0_LO = 8'h8A;
    localparam logic [7:0] ADDR_CNT1_LO = 8'h8B;
    localparam logic [7:0] ADDR_CNT0_HI = 8'h8C;
    localparam logic [7:0] ADDR_CNT1_HI = 8'h8D;
    localparam logic [7:0] RST_BYTE = 8'h00;

    localparam int B_OVF1 = 7;
    localparam int B_RUN1 = 6;
    localparam int B_OVF0 = 5;
    localparam int B_RUN0 = 4;
    localparam int B_EXT1 = 3;
    localparam int B_TRG1 = 2;
    localparam int B_EXT0 = 1;
    localparam int B_TRG0 = 0;

    // Mode register: timer 1 in the upper nibble, timer 0 in the lower
    localparam int M_GATE = 3;
    localparam int M_SRC = 2;
    localparam int M_MODE_HI = 1;
    localparam int NIB1 = 4;

    localparam logic [4:0] PRESC_MAX = 5'h1F;

    typedef enum logic [1:0] {
        MODE_13BIT = 2'b00,
        MODE_16BIT = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT = 2'b11
    } tmr_mode_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_s;

    typedef struct packed {
        logic ext_pin_zero;
        logic ext_pin_one;
        logic cnt_pin_zero;
        logic cnt_pin_one;
    } tmr_pins_s;
endpackage

// [hw/dual_timer.sv]
/*
 Two 8051-style timer/counters with their shared control register and the
 two external interrupt flags. Assumes a core that issues single-cycle SFR
 reads/writes, a machine-cycle strobe, and vector acknowledge pulses.
 Pins are synchronous to ref_clk.
*/
`timescale 1ns/1ps
module dual_timer
    import tmr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire sfr_req_s sfr_req,
    output logic [7:0] sfr_rdata,
    input wire logic mach_cycle,
    input wire tmr_pins_s pins,
    input wire logic ack_ovf_zero,
    input wire logic ack_ovf_one,
    input wire logic ack_ext_zero,
    input wire logic ack_ext_one,
    output logic [3:0] irq_req,
    output logic baud_ovf_one
);
    logic [7:0] ctrl;
    logic [7:0] mode_sel;
    logic [7:0] cnt0_lo;
    logic [7:0] cnt0_hi;
    logic [7:0] cnt1_lo;
    logic [7:0] cnt1_hi;
    logic [3:0] pins_q;
    logic [7:0] next_cnt0_lo;
    logic [7:0] next_cnt0_hi;
    logic [7:0] next_cnt1_lo;
    logic [7:0] next_cnt1_hi;
    logic ovf0;
    logic ovf1;
    logic ovf1_baud;
    logic tick0;
    logic tick1;
    logic ext_fall0;
    logic ext_fall1;
    logic run_bit_one;
    logic run_bit_zero;
    logic ext_irq_trigger_one;
    logic ext_irq_trigger_zero;
    logic ovf_flag_one;
    logic ovf_flag_zero;
    logic ext_irq_flag_one;
    logic ext_irq_flag_zero;
    logic ctrl_wr;
    logic set_ovf_one;

    function automatic logic wr_hit(input sfr_req_s r, input logic [7:0] a);
        wr_hit = r.wr && (r.addr == a);
    endfunction

    // One tick per counted event: machine cycle or pin falling edge
    function automatic logic count_tick(input logic [3:0] nib, input logic run, input logic ext_pin,
                                        input logic cyc, input logic fall);
        logic src;
        src = nib[M_SRC] ? fall : cyc;
        count_tick = run && (!nib[M_GATE] || ext_pin) && src;
    endfunction

    tmr_mode_e mode0;
    tmr_mode_e mode1;
    assign mode0 = tmr_mode_e'(mode_sel[M_MODE_HI:0]);
    assign mode1 = tmr_mode_e'(mode_sel[NIB1+M_MODE_HI:NIB1]);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pins_q <= 4'h0;
        end else begin
            pins_q <= {pins.ext_pin_one, pins.ext_pin_zero, pins.cnt_pin_one, pins.cnt_pin_zero};
        end
    end

    assign ext_fall0 = pins_q[2] && !pins.ext_pin_zero;
    assign ext_fall1 = pins_q[3] && !pins.ext_pin_one;

    assign tick0 = count_tick(mode_sel[3:0], ctrl[B_RUN0], pins.ext_pin_zero, mach_cycle,
                              pins_q[0] && !pins.cnt_pin_zero);
    // Timer 1 runs on its own bit even while timer 0 borrows that bit in split mode
    assign tick1 = count_tick(mode_sel[7:4], ctrl[B_RUN1], pins.ext_pin_one, mach_cycle,
                              pins_q[1] && !pins.cnt_pin_one);

    // Timer 0 counting
    always_comb begin
        next_cnt0_lo = cnt0_lo;
        next_cnt0_hi = cnt0_hi;
        ovf0 = 1'b0;
        ovf1 = 1'b0;
        case (mode0)
            MODE_13BIT: begin
                if (tick0) begin
                    next_cnt0_lo = {cnt0_lo[7:5], cnt0_lo[4:0] + 5'h01};
                    if (cnt0_lo[4:0] == PRESC_MAX) begin
                        next_cnt0_hi = cnt0_hi + 8'h01;
                        ovf0 = (cnt0_hi == 8'hFF);
                    end
                end
            end
            MODE_16BIT: begin
                if (tick0) begin
                    next_cnt0_lo = cnt0_lo + 8'h01;
                    if (cnt0_lo == 8'hFF) begin
                        next_cnt0_hi = cnt0_hi + 8'h01;
                        ovf0 = (cnt0_hi == 8'hFF);
                    end
                end
            end
            MODE_RELOAD: begin
                if (tick0) begin
                    next_cnt0_lo = (cnt0_lo == 8'hFF) ? cnt0_hi : cnt0_lo + 8'h01;
                    ovf0 = (cnt0_lo == 8'hFF);
                end
            end
            MODE_SPLIT: begin
                if (tick0) begin
                    next_cnt0_lo = cnt0_lo + 8'h01;
                    ovf0 = (cnt0_lo == 8'hFF);
                end
                if (ctrl[B_RUN1] && mach_cycle) begin
                    next_cnt0_hi = cnt0_hi + 8'h01;
                    ovf1 = (cnt0_hi == 8'hFF);
                end
            end
            default: begin
                next_cnt0_lo = cnt0_lo;
            end
        endcase
    end

    // Timer 1 counting
    always_comb begin
        next_cnt1_lo = cnt1_lo;
        next_cnt1_hi = cnt1_hi;
        ovf1_baud = 1'b0;
        case (mode1)
            MODE_13BIT: begin
                if (tick1) begin
                    next_cnt1_lo = {cnt1_lo[7:5], cnt1_lo[4:0] + 5'h01};
                    if (cnt1_lo[4:0] == PRESC_MAX) begin
                        next_cnt1_hi = cnt1_hi + 8'h01;
                        ovf1_baud = (cnt1_hi == 8'hFF);
                    end
                end
            end
            MODE_16BIT: begin
                if (tick1) begin
                    next_cnt1_lo = cnt1_lo + 8'h01;
                    if (cnt1_lo == 8'hFF) begin
                        next_cnt1_hi = cnt1_hi + 8'h01;
                        ovf1_baud = (cnt1_hi == 8'hFF);
                    end
                end
            end
            MODE_RELOAD: begin
                if (tick1) begin
                    next_cnt1_lo = (cnt1_lo == 8'hFF) ? cnt1_hi : cnt1_lo + 8'h01;
                    ovf1_baud = (cnt1_lo == 8'hFF);
                end
            end
            MODE_SPLIT: begin
                next_cnt1_lo = cnt1_lo;
            end
            default: begin
                next_cnt1_lo = cnt1_lo;
            end
        endcase
    end

    assign baud_ovf_one = ovf1_baud;

    // Count bytes: software write wins over counting in the same cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt0_lo <= RST_BYTE;
        end else begin
            cnt0_lo <= wr_hit(sfr_req, ADDR_CNT0_LO) ? sfr_req.wdata : next_cnt0_lo;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt0_hi <= RST_BYTE;
        end else begin
            cnt0_hi <= wr_hit(sfr_req, ADDR_CNT0_HI) ? sfr_req.wdata : next_cnt0_hi;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt1_lo <= RST_BYTE;
        end else begin
            cnt1_lo <= wr_hit(sfr_req, ADDR_CNT1_LO) ? sfr_req.wdata : next_cnt1_lo;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt1_hi <= RST_BYTE;
        end else begin
            cnt1_hi <= wr_hit(sfr_req, ADDR_CNT1_HI) ? sfr_req.wdata : next_cnt1_hi;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mode_sel <= RST_BYTE;
        end else if (wr_hit(sfr_req, ADDR_MODE)) begin
            mode_sel <= sfr_req.wdata;
        end
    end

    assign ctrl_wr = wr_hit(sfr_req, ADDR_CTRL);
    // Split mode hands the timer 1 flag to the high byte of timer 0
    assign set_ovf_one = ovf1 || (mode0 != MODE_SPLIT && ovf1_baud);

    // Run and trigger bits are plain software bits; writing run touches no count
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            run_bit_one <= 1'b0;
            run_bit_zero <= 1'b0;
            ext_irq_trigger_one <= 1'b0;
            ext_irq_trigger_zero <= 1'b0;
        end else if (ctrl_wr) begin
            run_bit_one <= sfr_req.wdata[B_RUN1];
            run_bit_zero <= sfr_req.wdata[B_RUN0];
            ext_irq_trigger_one <= sfr_req.wdata[B_TRG1];
            ext_irq_trigger_zero <= sfr_req.wdata[B_TRG0];
        end
    end

    // Overflow flags: hardware set beats a vector clear, which beats a write
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ovf_flag_one <= 1'b0;
        end else if (set_ovf_one) begin
            ovf_flag_one <= 1'b1;
        end else if (ack_ovf_one) begin
            ovf_flag_one <= 1'b0;
        end else if (ctrl_wr) begin
            ovf_flag_one <= sfr_req.wdata[B_OVF1];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ovf_flag_zero <= 1'b0;
        end else if (ovf0) begin
            ovf_flag_zero <= 1'b1;
        end else if (ack_ovf_zero) begin
            ovf_flag_zero <= 1'b0;
        end else if (ctrl_wr) begin
            ovf_flag_zero <= sfr_req.wdata[B_OVF0];
        end
    end

    // External flags: edge mode latches, level mode tracks the pin
    // Level mode ignores acks and writes, so a held pin keeps requesting
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ext_irq_flag_one <= 1'b0;
        end else if (!ext_irq_trigger_one) begin
            ext_irq_flag_one <= !pins.ext_pin_one;
        end else if (ext_fall1) begin
            ext_irq_flag_one <= 1'b1;
        end else if (ack_ext_one) begin
            ext_irq_flag_one <= 1'b0;
        end else if (ctrl_wr) begin
            ext_irq_flag_one <= sfr_req.wdata[B_EXT1];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ext_irq_flag_zero <= 1'b0;
        end else if (!ext_irq_trigger_zero) begin
            ext_irq_flag_zero <= !pins.ext_pin_zero;
        end else if (ext_fall0) begin
            ext_irq_flag_zero <= 1'b1;
        end else if (ack_ext_zero) begin
            ext_irq_flag_zero <= 1'b0;
        end else if (ctrl_wr) begin
            ext_irq_flag_zero <= sfr_req.wdata[B_EXT0];
        end
    end

    // Register view of the loose control bits; each bit keeps a single writer
    always_comb begin
        ctrl = RST_BYTE;
        ctrl[B_OVF1] = ovf_flag_one;
        ctrl[B_RUN1] = run_bit_one;
        ctrl[B_OVF0] = ovf_flag_zero;
        ctrl[B_RUN0] = run_bit_zero;
        ctrl[B_EXT1] = ext_irq_flag_one;
        ctrl[B_TRG1] = ext_irq_trigger_one;
        ctrl[B_EXT0] = ext_irq_flag_zero;
        ctrl[B_TRG0] = ext_irq_trigger_zero;
    end

    assign irq_req = {ovf_flag_one, ext_irq_flag_one, ovf_flag_zero, ext_irq_flag_zero};

    // Registered read data; unmapped addresses read zero
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sfr_rdata <= RST_BYTE;
        end else if (sfr_req.rd) begin
            case (sfr_req.addr)
                ADDR_CTRL: sfr_rdata <= ctrl;
                ADDR_MODE: sfr_rdata <= mode_sel;
                ADDR_CNT0_LO: sfr_rdata <= cnt0_lo;
                ADDR_CNT1_LO: sfr_rdata <= cnt1_lo;
                ADDR_CNT0_HI: sfr_rdata <= cnt0_hi;
                ADDR_CNT1_HI: sfr_rdata <= cnt1_hi;
                default: sfr_rdata <= RST_BYTE;
            endcase
        end
    end
endmodule

// [sim/dual_timer_properties.sv]
/* Checker for dual_timer ports: flags, run bits, read port.
   Assumes control and mode change only through SFR writes. */
`timescale 1ns/1ps
module dual_timer_properties
    import tmr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire sfr_req_s sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire tmr_pins_s pins,
    input wire logic ack_ext_zero,
    input wire logic [3:0] irq_req,
    input wire logic baud_ovf_one
);
    logic [7:0] ctrl;
    logic [7:0] mreg;
    logic ctrl_wr;
    assign ctrl_wr = sfr_req.wr && sfr_req.addr == ADDR_CTRL;
    // Shadows; flag bits go stale, only run, trigger and mode bits are used
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl <= RST_BYTE;
            mreg <= RST_BYTE;
        end else if (sfr_req.wr) begin
            if (ctrl_wr) ctrl <= sfr_req.wdata;
            if (sfr_req.addr == ADDR_MODE) mreg <= sfr_req.wdata;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence fall0_s;
        ctrl[B_TRG0] && $fell(pins.ext_pin_zero) && !ack_ext_zero;
    endsequence
    sequence t1_wrap_s;
        baud_ovf_one && mreg[1:0] != 2'h3;
    endsequence
    edge_set_a: assert property (fall0_s |=> irq_req[0]) else $error("edge flag unset");
    ack_clear_a: assert property (ctrl[B_TRG0] && ack_ext_zero && !$fell(pins.ext_pin_zero)
        |=> !irq_req[0]) else $error("edge flag kept");
    lvl_follow_a: assert property ($past(nrst) && !$past(ctrl[B_TRG0])
        |-> irq_req[0] == !$past(pins.ext_pin_zero)) else $error("level flag off pin");
    // Overflow lands one edge after the wrap, so the run bit may be two edges back
    ovf0_run_a: assert property ($rose(irq_req[1])
        |-> $past(ctrl[B_RUN0]) || $past(ctrl[B_RUN0], 2) || $past(ctrl_wr)) else $error("ovf0 when off");
    baud_gate_a: assert property (baud_ovf_one |-> ctrl[B_RUN1] && mreg[NIB1+1:NIB1] != 2'h3
        && (!mreg[NIB1+M_GATE] || pins.ext_pin_one)) else $error("timer 1 ran when off");
    baud_flag_a: assert property (t1_wrap_s |-> ##[1:2] irq_req[3]) else $error("ovf1 unset");
    rdata_hold_a: assert property (!$past(sfr_req.rd) |-> $stable(sfr_rdata)) else $error("rdata moved");
    unmapped_zero_a: assert property (sfr_req.rd && (sfr_req.addr < ADDR_CTRL || sfr_req.addr > ADDR_CNT1_HI)
        |=> sfr_rdata == 8'h00) else $error("unmapped read");
endmodule
bind dual_timer dual_timer_properties chk (.ref_clk(ref_clk), .nrst(nrst), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .pins(pins), .ack_ext_zero(ack_ext_zero), .irq_req(irq_req),
    .baud_ovf_one(baud_ovf_one));

// [sim/pin_model.sv]
/* Pin side of the timer: interrupt/gate levels and count pin toggles.
   Assumes the bench sets levels and toggle enables on clock edges. */
`timescale 1ns/1ps
module pin_model
    import tmr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [1:0] ext_lvl,
    input wire logic [1:0] cnt_go,
    output tmr_pins_s pins
);
    // Idle high; a toggle enable makes one fall every two cycles
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pins <= '1;
        end else begin
            pins.ext_pin_zero <= ext_lvl[0];
            pins.ext_pin_one <= ext_lvl[1];
            pins.cnt_pin_zero <= pins.cnt_pin_zero ^ cnt_go[0];
            pins.cnt_pin_one <= pins.cnt_pin_one ^ cnt_go[1];
        end
    end
endmodule

// [sim/dual_timer_counter_with_ext_irq_flags_tb_top.sv]
/* Bench for dual_timer: SFR tasks, one task per scenario, verdict.
   Assumes pin_model on the pins and the bound checker. */
`timescale 1ns/1ps
module dual_timer_counter_with_ext_irq_flags_tb_top
    import tmr_pkg::*;
;
    logic ref_clk = 1'h0;
    logic nrst = 1'h0;
    logic mc = 1'h0;
    sfr_req_s req = '0;
    logic [3:0] ack = 4'h0;
    logic [1:0] ext_lvl = 2'h3;
    logic [1:0] cnt_go = 2'h0;
    tmr_pins_s pins;
    logic [7:0] rdata;
    logic [3:0] irq;
    logic baud;
    logic [7:0] v;
    logic [7:0] w;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    dual_timer dut (.ref_clk(ref_clk), .nrst(nrst), .sfr_req(req), .sfr_rdata(rdata), .mach_cycle(mc),
        .pins(pins), .ack_ovf_zero(ack[0]), .ack_ovf_one(ack[1]), .ack_ext_zero(ack[2]),
        .ack_ext_one(ack[3]), .irq_req(irq), .baud_ovf_one(baud));
    pin_model far (.ref_clk(ref_clk), .nrst(nrst), .ext_lvl(ext_lvl), .cnt_go(cnt_go), .pins(pins));
    always #12.5 ref_clk = ~ref_clk;
    // Run needs well under a thousand cycles; ceiling leaves wide margin
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end
    task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge ref_clk) req <= '{1'h1, 1'h0, a, d};
        @(posedge ref_clk) req <= '0;
    endtask
    task automatic rd(logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk) req <= '{1'h0, 1'h1, a, 8'h00};
        @(posedge ref_clk) req <= '0;
        #1 d = rdata;
    endtask
    task automatic ackp(int k);
        @(posedge ref_clk) ack[k] <= 1'h1;
        @(posedge ref_clk) ack[k] <= 1'h0;
        #1;
    endtask
    // Index 4 waits for the baud pulse; the caller judges the outcome
    task automatic wait_for(int b, int lim);
        for (int i = 0; i < lim && (b > 3 ? baud : irq[b]) !== 1'h1; i++) @(posedge ref_clk) #1;
    endtask
    task automatic s_regs();
        for (logic [7:0] a = ADDR_CTRL; a <= ADDR_CNT1_HI; a++) begin
            rd(a, v);
            chk("reset value", v, RST_BYTE);
            if (a >= ADDR_CNT0_LO) begin
                wr(a, a ^ 8'h5A);
                rd(a, v);
                chk("count byte", v, a ^ 8'h5A);
            end
        end
        rd(8'h90, v);
        chk("unmapped", v, 8'h00);
    endtask
    task automatic s_wrap(logic [7:0] md, logic [7:0] hi, logic [7:0] lo, logic [7:0] msk, logic [7:0] elo);
        @(posedge ref_clk) mc <= 1'h0;
        wr(ADDR_MODE, md);
        wr(ADDR_CNT0_HI, hi);
        wr(ADDR_CNT0_LO, lo);
        wr(ADDR_CTRL, 8'h10);
        rd(ADDR_CNT0_LO, v);
        chk("kept on start", v, lo);
        @(posedge ref_clk) mc <= 1'h1;
        wait_for(1, 100);
        chk("ovf0 set", irq[1], 1'h1);
        wr(ADDR_CTRL, 8'h20);
        rd(ADDR_CNT0_HI, v);
        chk("high byte", v, md == 8'h02 ? hi : 8'h00);
        rd(ADDR_CNT0_LO, v);
        chk("low byte", v & msk, elo);
        ackp(0);
        chk("ovf0 ack", irq[1], 1'h0);
    endtask
    // Machine cycles keep running, so only pin falls may count
    task automatic s_gate();
        wr(ADDR_MODE, 8'h0D);
        wr(ADDR_CNT0_LO, 8'h00);
        wr(ADDR_CTRL, 8'h10);
        for (int g = 0; g < 2; g++) begin
            @(posedge ref_clk) ext_lvl[0] <= g[0];
            @(posedge ref_clk) cnt_go[0] <= 1'h1;
            repeat (6) @(posedge ref_clk);
            cnt_go[0] <= 1'h0;
            rd(ADDR_CNT0_LO, v);
            chk("pin count", v, g ? 8'h03 : 8'h00);
        end
    endtask
    task automatic s_ext();
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_CTRL, i ? 8'h04 : 8'h01);
            @(posedge ref_clk) ext_lvl[i] <= 1'h0;
            repeat (3) @(posedge ref_clk);
            ext_lvl[i] <= 1'h1;
            repeat (3) @(posedge ref_clk) #1;
            chk("edge flag", irq[2*i], 1'h1);
            ackp(2 + i);
            chk("edge flag ack", irq[2*i], 1'h0);
            wr(ADDR_CTRL, 8'h00);
            @(posedge ref_clk) ext_lvl[i] <= 1'h0;
            repeat (3) @(posedge ref_clk);
            ackp(2 + i);
            chk("level flag", irq[2*i], 1'h1);
            @(posedge ref_clk) ext_lvl[i] <= 1'h1;
            repeat (3) @(posedge ref_clk) #1;
            chk("level flag low", irq[2*i], 1'h0);
        end
    endtask
    task automatic s_split();
        wr(ADDR_MODE, 8'h10);
        wr(ADDR_CNT1_HI, 8'hFF);
        wr(ADDR_CNT1_LO, 8'hF0);
        wr(ADDR_CTRL, 8'h40);
        wait_for(3, 100);
        chk("ovf1 set", irq[3], 1'h1);
        ackp(1);
        chk("ovf1 ack", irq[3], 1'h0);
        wr(ADDR_MODE, 8'h13);
        wr(ADDR_CNT0_HI, 8'hFE);
        wr(ADDR_CNT1_HI, 8'hFF);
        wait_for(3, 100);
        chk("split high ovf", irq[3], 1'h1);
        chk("split low idle", irq[1], 1'h0);
        wait_for(4, 300);
        chk("baud pulse", baud, 1'h1);
        wr(ADDR_MODE, 8'h33);
        rd(ADDR_CNT1_LO, v);
        rd(ADDR_CNT1_LO, w);
        chk("timer 1 held", w, v);
    endtask
    task automatic conclude();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        nrst <= 1'h1;
        s_regs();
        s_wrap(8'h00, 8'hFF, 8'h1E, 8'h10, 8'h00);
        s_wrap(8'h01, 8'hFF, 8'hFC, 8'hF0, 8'h00);
        s_wrap(8'h02, 8'hF0, 8'hFE, 8'hF0, 8'hF0);
        s_gate();
        s_ext();
        s_split();
        conclude();
    end
endmodule
